// ### lerc_pkg.sv
// Shared constants and types for the logic element register control block
package lerc_pkg;

  // ==========================================================================
  // Register map (APB byte addresses)
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0010;

  // ==========================================================================
  // Control register field positions
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_MODE_W      = 3;
  localparam int CTRL_CLRSEL_BIT  = 3;
  localparam int CTRL_CNTEN_BIT   = 4;

  // ==========================================================================
  // Datapath sizes and values after reset
  localparam int         CNT_W        = 8;
  localparam int         NDRV         = 4;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic       ELEM_RESET   = 1'b0;
  localparam logic       BUS_RESET    = 1'b1;

  // ==========================================================================
  // Element register clear/preset configurations
  typedef enum logic [2:0] {
    MODE_ACLR,
    MODE_APRE,
    MODE_ACLR_APRE,
    MODE_ALOAD_CLR,
    MODE_ALOAD_PRE,
    MODE_ALOAD
  } lerc_mode_t;

  // Control register image
  typedef struct packed {
    logic [26:0] rsv;
    logic        cnt_en;
    logic        clr_sel;
    logic [2:0]  mode;
  } lerc_ctrl_t;

  // Status register image
  typedef struct packed {
    logic [19:0]      rsv;
    logic             contention;
    logic             floating;
    logic             bus_val;
    logic             elem_q;
    logic [CNT_W-1:0] count;
  } lerc_status_t;

endpackage

// ### lerc_top.sv
// Logic element register control: clearable counter, element register, tri-state emulation
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps

// Functional notes
// - Clearable counter counts one direction, sync clear
// - Sync clear sits in cascade-in position
// - Each bit uses data and carry lookups
// - Two-input selector gives synchronous parallel load
// - Clear ANDed after selector, overrides load, count
// - Contending bus drivers resolve to low
// - Undriven emulated bus reads high
// - Element controls: load data, two block lines
// - Async clear selectable from either block line
// - Async load takes load data immediately
// - Clear and preset controls are active low
// - Both used: first presets, second clears
module lerc_top (
  // APB slave
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [lerc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Clearable counter, same clock as user logic
  input  wire logic                        cnt_clear_n,
  input  wire logic                        cnt_load,
  input  wire logic [lerc_pkg::CNT_W-1:0]  cnt_load_value,
  output logic      [lerc_pkg::CNT_W-1:0]  count,
  // Element register
  input  wire logic                        elem_d,
  input  wire logic                        async_load_data_in,
  input  wire logic                        block_ctrl_first,
  input  wire logic                        block_ctrl_second,
  output logic                             elem_q,
  // Emulated internal tri-state bus
  input  wire logic [lerc_pkg::NDRV-1:0]   tri_oe,
  input  wire logic [lerc_pkg::NDRV-1:0]   tri_data,
  output logic                             bus_val,
  output logic                             bus_contention,
  output logic                             bus_floating
);
  import lerc_pkg::*;

  // ==========================================================================
  // Lookup functions of one counter bit
  // Data lookup: toggle when the carry in and the enable are both high
  function automatic logic lut_data(input logic q, input logic cin, input logic en);
    lut_data = q ^ (cin & en);
  endfunction

  // Carry lookup: ripple to the next bit only while this one is set
  function automatic logic lut_carry(input logic q, input logic cin, input logic en);
    lut_carry = q & cin & en;
  endfunction

  // ==========================================================================
  // APB register file
  lerc_ctrl_t   ctrl;
  lerc_status_t status;
  logic         acc_phase;
  logic         hit_ctrl;
  logic         hit_status;
  logic         wr_done;
  logic         rd_capture;

  assign acc_phase  = psel & penable;
  assign hit_ctrl   = (paddr == OFF_CTRL);
  assign hit_status = (paddr == OFF_STATUS);
  assign wr_done    = acc_phase & pready & pwrite & hit_ctrl;
  assign rd_capture = acc_phase & ~pready;

  // One wait state: every access completes on its second access-phase edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_capture;
      pslverr <= rd_capture & ~(hit_ctrl | hit_status);
      if (rd_capture) begin
        prdata <= (hit_ctrl & ~pwrite) ? ctrl :
                  (hit_status & ~pwrite) ? status : 32'h0000_0000;
      end
    end
  end

  // Control register, written only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_done) begin
      ctrl <= {27'h000_0000, pwdata[CTRL_CNTEN_BIT:CTRL_MODE_LSB]};
    end
  end

  // Status register shows the block's own state
  assign status = '{rsv: 20'h0_0000, contention: bus_contention, floating: bus_floating,
                    bus_val: bus_val, elem_q: elem_q, count: count};

  // ==========================================================================
  // Clearable counter
  logic [CNT_W:0]   carry;
  logic [CNT_W-1:0] next_count_inc;
  logic [CNT_W-1:0] next_count_sel;
  logic [CNT_W-1:0] next_count;

  // Carry in is tied high and no direction input exists: the count only goes up
  assign carry[0] = 1'b1;

  // Two lookups per bit: count data and fast carry
  genvar gi;
  generate
    for (gi = 0; gi < CNT_W; gi++) begin : g_bit
      assign next_count_inc[gi] = lut_data(count[gi], carry[gi], ctrl.cnt_en);
      assign carry[gi+1]        = lut_carry(count[gi], carry[gi], ctrl.cnt_en);
    end
  endgenerate

  // Selector then AND with the clear, so clear beats load and count.
  // The clear sits where the cascade input would be: after the lookups, before the flop.
  assign next_count_sel = cnt_load ? cnt_load_value : next_count_inc;
  assign next_count     = next_count_sel & {CNT_W{cnt_clear_n}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // ==========================================================================
  // Element register clear/preset steering
  lerc_mode_t elem_mode;
  logic       sel_clr_n;
  logic       aclr_n;
  logic       apre_n;
  logic       load_pre_n;
  logic       load_clr_n;

  assign elem_mode  = lerc_mode_t'(ctrl.mode);
  // Either block line may be the plain clear
  assign sel_clr_n  = ctrl.clr_sel ? block_ctrl_second : block_ctrl_first;
  // Async load is a data-steered preset or clear while the first line is low
  assign load_pre_n = block_ctrl_first | ~async_load_data_in;
  assign load_clr_n = block_ctrl_first | async_load_data_in;

  // Only the load data and the two block lines reach these, all active low
  always_comb begin
    aclr_n = 1'b1;
    apre_n = 1'b1;
    case (elem_mode)
      MODE_ACLR:      aclr_n = sel_clr_n;
      MODE_APRE:      apre_n = block_ctrl_first;
      MODE_ACLR_APRE: begin
        apre_n = block_ctrl_first;
        aclr_n = block_ctrl_second;
      end
      MODE_ALOAD_CLR: begin
        apre_n = load_pre_n;
        aclr_n = load_clr_n & block_ctrl_second;
      end
      MODE_ALOAD_PRE: begin
        apre_n = load_pre_n & block_ctrl_second;
        aclr_n = load_clr_n;
      end
      MODE_ALOAD: begin
        apre_n = load_pre_n;
        aclr_n = load_clr_n;
      end
      default:        aclr_n = sel_clr_n;
    endcase
  end

  // Controls act without the clock; clear wins if both are low.
  // Limitation: changing the mode while a line is low can glitch the register.
  always_ff @(posedge pclk or negedge presetn or negedge aclr_n or negedge apre_n) begin
    if (!presetn) begin
      elem_q <= ELEM_RESET;
    end else if (!aclr_n) begin
      elem_q <= 1'b0;
    end else if (!apre_n) begin
      elem_q <= 1'b1;
    end else begin
      elem_q <= elem_d;
    end
  end

  // ==========================================================================
  // Tri-state emulation: a multiplexer, never a real floating net
  logic [2:0] oe_count;
  logic       next_bus;

  always_comb begin
    oe_count = 3'h0;
    for (int i = 0; i < NDRV; i++) begin
      oe_count = oe_count + {2'h0, tri_oe[i]};
    end
  end

  assign next_bus = (oe_count == 3'h0) ? 1'b1 :
                    (oe_count != 3'h1) ? 1'b0 :
                    |(tri_oe & tri_data);

  // Registered so the outputs stay glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_val        <= BUS_RESET;
      bus_contention <= 1'b0;
      bus_floating   <= 1'b0;
    end else begin
      bus_val        <= next_bus;
      bus_contention <= (oe_count > 3'h1);
      bus_floating   <= (oe_count == 3'h0);
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_plain_count;
    cnt_clear_n && !cnt_load;
  endsequence

  sequence s_load_held;
    (elem_mode == MODE_ALOAD && !block_ctrl_first && $stable(async_load_data_in)) [*2];
  endsequence

  sequence s_both_first;
    (elem_mode == MODE_ACLR_APRE && !block_ctrl_first && block_ctrl_second) [*2];
  endsequence

  sequence s_both_second;
    (elem_mode == MODE_ACLR_APRE && !block_ctrl_second) [*2];
  endsequence

  clear_wins_a: assert property (!cnt_clear_n |=> count == 8'h00)
    else $error("counter not cleared");
  load_sel_a: assert property (cnt_clear_n && cnt_load |=> count == $past(cnt_load_value))
    else $error("counter load value lost");
  count_step_a: assert property (s_plain_count and ctrl.cnt_en |=> count == 8'($past(count) + 8'h01))
    else $error("counter did not step by one");
  count_hold_a: assert property (s_plain_count and !ctrl.cnt_en |=> $stable(count))
    else $error("counter moved while disabled");
  bus_low_a: assert property ($countones(tri_oe) > 1 |=> !bus_val && bus_contention)
    else $error("contending bus not low");
  bus_high_a: assert property (tri_oe == 4'h0 |=> bus_val && bus_floating)
    else $error("undriven bus not high");
  aload_data_a: assert property (s_load_held |-> elem_q == async_load_data_in)
    else $error("async load data not in register");
  preset_first_a: assert property (s_both_first |-> elem_q)
    else $error("first line did not preset");
  clear_second_a: assert property (s_both_second |-> !elem_q)
    else $error("second line did not clear");
  sel_clear_a: assert property ((elem_mode == MODE_ACLR && !sel_clr_n) [*2] |-> !elem_q)
    else $error("selected clear line ignored");

  // ==========================================================================
  // Bus handshake checks: every access gets exactly one wait state
  sequence s_first_access;
    psel && penable && !pready;
  endsequence

  sequence s_answer;
    psel && penable && pready;
  endsequence

  one_wait_a: assert property (s_first_access |=> pready)
    else $error("access not answered after one wait state");
  // Ready is a one-cycle pulse; a master that holds penable sees another one two edges later
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag raised without ready");
  // Unmapped reads return zero so stale data never leaks out
  unmapped_err_a: assert property (s_first_access && !(hit_ctrl || hit_status) |=>
                                   pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  ctrl_read_a: assert property (s_first_access && !pwrite && hit_ctrl |=> prdata == $past(ctrl))
    else $error("control read data wrong");
  status_read_a: assert property (s_first_access && !pwrite && hit_status |=> prdata[CNT_W-1:0] == $past(count))
    else $error("status read count wrong");
  // Only the low five bits are stored; the reserved bits must read back as zero
  ctrl_write_a: assert property (s_answer && pwrite && hit_ctrl |=>
                                 ctrl == {27'h000_0000, $past(pwdata[CTRL_CNTEN_BIT:CTRL_MODE_LSB])})
    else $error("control write not stored");
  // Status is read only: a write there, or anywhere else, leaves the control word alone
  ctrl_keep_a: assert property (s_answer && pwrite && !hit_ctrl |=> $stable(ctrl))
    else $error("control changed by a foreign write");

  // ==========================================================================
  // Counter checks on the carry chain and the clear
  // All ones with the enable high must roll over to zero through the top carry
  carry_wrap_a: assert property (s_plain_count and carry[CNT_W] |=> count == 8'h00)
    else $error("carry out did not wrap the counter");
  // Clear in the same cycle as a load: the AND after the selector must win
  clear_over_load_a: assert property (!cnt_clear_n && cnt_load |=> count == 8'h00)
    else $error("load beat the clear");

  // ==========================================================================
  // Element register checks for the remaining modes
  sequence s_preset_only;
    (elem_mode == MODE_APRE && !block_ctrl_first) [*2];
  endsequence

  sequence s_load_clear;
    (elem_mode == MODE_ALOAD_CLR && !block_ctrl_first && block_ctrl_second && $stable(async_load_data_in)) [*2];
  endsequence

  sequence s_load_preset;
    (elem_mode == MODE_ALOAD_PRE && block_ctrl_first && !block_ctrl_second) [*2];
  endsequence

  preset_only_a: assert property (s_preset_only |-> elem_q)
    else $error("first line did not preset alone");
  aload_clr_a: assert property (s_load_clear |-> elem_q == async_load_data_in)
    else $error("load with clear lost the load data");
  aload_pre_a: assert property (s_load_preset |-> elem_q)
    else $error("second line did not preset in load mode");
  // With both block lines resting high the register is a plain flop on elem_d.
  // Two idle samples are needed because a line may fall just after an edge.
  lines_idle_a: assert property ((block_ctrl_first && block_ctrl_second) ##1 (block_ctrl_first && block_ctrl_second)
                                 |-> elem_q == $past(elem_d))
    else $error("idle block lines disturbed the register");

  // ==========================================================================
  // Bus flags must agree with the resolved value they describe
  float_high_a: assert property (bus_floating |-> bus_val && !bus_contention)
    else $error("floating flag without a high bus");
  contend_low_a: assert property (bus_contention |-> !bus_val)
    else $error("contention flag without a low bus");
  // A single enabled driver passes its data straight through
  one_driver_a: assert property ($countones(tri_oe) == 1 |=>
                                 bus_val == $past(|(tri_oe & tri_data)))
    else $error("single driver value not passed");

endmodule

// ### lerc_user.sv
// Model of the user logic around the block: tri-state drivers and block control lines
`timescale 1ns/1ps
module lerc_user (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // Requests from the bench, active high
  input  wire logic [lerc_pkg::NDRV-1:0] drv_oe,
  input  wire logic [lerc_pkg::NDRV-1:0] drv_data,
  input  wire logic                      first_req,
  input  wire logic                      second_req,
  // Towards the block
  output logic      [lerc_pkg::NDRV-1:0] tri_oe,
  output logic      [lerc_pkg::NDRV-1:0] tri_data,
  output logic                           block_ctrl_first,
  output logic                           block_ctrl_second
);
  import lerc_pkg::*;
  // ==========================================================================
  // Drivers: a released driver shows inverted data, so stale levels never help
  assign tri_oe   = drv_oe;
  assign tri_data = drv_data ^ ~drv_oe;
  // Control lines rest high when unused and during reset
  assign block_ctrl_first  = !(presetn && first_req);
  assign block_ctrl_second = !(presetn && second_req);
endmodule

// ### testbench.sv
// Self-checking bench for the logic element register control block
`timescale 1ns/1ps
module testbench;
  import lerc_pkg::*;
  // ==========================================================================
  // Stimulus and observation
  logic              pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0, prdata, rd;
  logic              pready, pslverr, err, elem_q, bus_val, bus_contention, bus_floating;
  logic              cnt_clear_n = 1'h1, cnt_load = 1'h0, elem_d = 1'h0, async_load_data_in = 1'h0;
  logic              first_req = 1'h0, second_req = 1'h0, block_ctrl_first, block_ctrl_second;
  logic [CNT_W-1:0]  cnt_load_value = 8'h00, count, held;
  logic [NDRV-1:0]   drv_oe = 4'h0, drv_data = 4'h0, tri_oe, tri_data;
  int                bad_count = 0, n_checks = 0;
  // Bus cases: enables, data, expected {value, contention, floating}
  logic [3:0]        oe_t [5] = '{4'h1, 4'h4, 4'h0, 4'h6, 4'h8};
  logic [3:0]        dat_t [5] = '{4'h1, 4'hb, 4'h0, 4'hf, 4'h8};
  logic [2:0]        bus_exp [5] = '{3'h4, 3'h0, 3'h5, 3'h2, 3'h4};
  // Element cases: control word and {d, first, second, load data, expected q}
  logic [7:0]        el_ctrl [10] = '{8'h10, 8'h18, 8'h18, 8'h11, 8'h12, 8'h12, 8'h13, 8'h13, 8'h15, 8'h14};
  logic [4:0]        el_v [10] = '{5'h18, 5'h14, 5'h19, 5'h09, 5'h09, 5'h1c, 5'h0b, 5'h18, 5'h0b, 5'h05};

  always #12.5 pclk = ~pclk;

  lerc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                .cnt_clear_n, .cnt_load, .cnt_load_value, .count, .elem_d, .async_load_data_in,
                .block_ctrl_first, .block_ctrl_second, .elem_q, .tri_oe, .tri_data, .bus_val,
                .bus_contention, .bus_floating);
  lerc_user partner (.pclk, .presetn, .drv_oe, .drv_data, .first_req, .second_req, .tri_oe, .tri_data,
                     .block_ctrl_first, .block_ctrl_second);

  // ==========================================================================
  // Shared tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; it waits as long as the slave needs, only the watchdog ends a hang
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1);
    chk("apb wait", 32'h2, n);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task t_regs;
    apb(1'h0, OFF_CTRL, 32'h0);
    chk("ctrl reset", CTRL_RESET, rd);
    apb(1'h1, OFF_CTRL, 32'hffff_ffe5);
    apb(1'h1, OFF_STATUS, 32'hffff_ffff);
    chk("status write err", 32'h0, err);
    apb(1'h0, OFF_CTRL, 32'h0);
    chk("ctrl reserved", 32'h5, rd);
    apb(1'h1, OFF_CTRL, CTRL_RESET);
    apb(1'h0, 8'h08, 32'h0);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk("status flags", 32'h6, rd[11:8]);
  endtask

  task t_counter;
    @(posedge pclk);
    cnt_load <= 1'h1;
    cnt_load_value <= 8'h05;
    @(posedge pclk);
    cnt_load <= 1'h0;
    @(negedge pclk);
    chk("load", 32'h5, count);
    @(negedge pclk);
    chk("step", 32'h6, count);
    @(posedge pclk);
    cnt_clear_n <= 1'h0;
    cnt_load <= 1'h1;
    cnt_load_value <= 8'hff;
    @(posedge pclk);
    cnt_clear_n <= 1'h1;
    @(negedge pclk);
    chk("clear wins", 32'h0, count);
    @(posedge pclk);
    cnt_load <= 1'h0;
    @(negedge pclk);
    chk("load ff", 32'hff, count);
    @(negedge pclk);
    chk("wrap", 32'h0, count);
    apb(1'h1, OFF_CTRL, 32'h0);
    @(negedge pclk);
    held = count;
    repeat (3) @(negedge pclk);
    chk("hold", held, count);
    apb(1'h1, OFF_CTRL, CTRL_RESET);
  endtask

  task t_bus;
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      drv_oe <= oe_t[i];
      drv_data <= dat_t[i];
      @(posedge pclk);
      @(negedge pclk);
      chk("bus", bus_exp[i], {bus_val, bus_contention, bus_floating});
    end
  endtask

  // The register first takes d on a clock, then a control moves it against d with no clock, save one case where the unselected line leaves it at d
  task t_elem;
    for (int i = 0; i < 10; i++) begin
      apb(1'h1, OFF_CTRL, {24'h0, el_ctrl[i]});
      @(posedge pclk);
      elem_d <= el_v[i][4];
      @(posedge pclk);
      first_req <= el_v[i][3];
      second_req <= el_v[i][2];
      async_load_data_in <= el_v[i][1];
      @(negedge pclk);
      chk("elem_q", el_v[i][0], elem_q);
      repeat (3) @(posedge pclk);
      first_req <= 1'h0;
      second_req <= 1'h0;
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    chk("reset", 32'h2, {count, elem_q, bus_val, bus_floating});
    presetn <= 1'h1;
    t_regs();
    t_counter();
    t_bus();
    t_elem();
    wrap_up();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    wrap_up();
  end
endmodule
